// File: core/rr_pick.sv
/*
 * round-robin picker: first requester after the last winner, wrapping.
 * assumes last is one-hot or zero; zero starts the search at index 0.
 */
module rr_pick #(parameter int N = 8) (
	input wire logic [N-1:0] req,
	input wire logic [N-1:0] last,
	output logic [N-1:0] pick
);
	always_comb begin
		int base;
		int idx;
		logic found;
		base = N - 1;
		idx = 0;
		found = 1'b0;
		pick = '0;
		for (int i = 0; i < N; i++) begin
			if (last[i]) begin
				base = i;
			end
		end
		for (int k = 1; k <= N; k++) begin
			idx = (base + k) % N;
			if (!found && req[idx]) begin
				pick[idx] = 1'b1;
				found = 1'b1;
			end
		end
	end
endmodule // rr_pick

// File: core/sec_arbiter.sv
/*
 * secondary bus arbiter with its control and clock status registers.
 * assumes request and status pins are asynchronous, config port is on clk.
 */
// How it works
// - clock status bits 7:1 always read as zero.
// - clock status bit 0 reads 1 while secondary clocks stopped; not writable.
// - two priority tiers, round-robin among requesters within each tier.
// - control register resets to 40h, only the bridge in the high tier.
// - park bit set parks the idle bus on the bridge.
// - park bit clear parks the idle bus on the last owner.
// - control bit 6 puts the bridge in the high (1) or low (0) tier.
// - control bits 5:0 put external masters 5:0 in high (1) or low (0) tier.
// - every external tier bit resets to 0.
`include "arb_map.svh"
module sec_arbiter (
	input wire logic clk,
	input wire logic nrst,
	input wire arb_pkg::cfg_req_t cfg,
	output logic [7:0] cfg_rdata,
	input wire logic [`NUM_EXT-1:0] req_n,
	input wire logic bridge_req,
	input wire logic bus_idle,
	input wire logic sec_clk_stopped,
	output logic [`NUM_EXT-1:0] gnt_n,
	output logic bridge_gnt
);
	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; first stage is read only by the second
	logic [`NUM_EXT+1:0] sync1_r, sync2_r, sync1_nxt, sync2_nxt;
	always_comb begin
		sync1_nxt = {sec_clk_stopped, bus_idle, ~req_n};
		sync2_nxt = sync1_r;
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
		end
	end
	logic stop_s, idle_s;
	logic [`NUM_MST-1:0] req_v;
	assign stop_s = sync2_r[`NUM_EXT+1];
	assign idle_s = sync2_r[`NUM_EXT];
	assign req_v = {bridge_req, sync2_r[`NUM_EXT-1:0]};

	////////////////////////////////////////////////////////////////////////////////
	// registers
	arb_pkg::arb_ctrl_t ctrl_r, ctrl_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	always_comb begin
		ctrl_nxt = ctrl_r;
		rdata_nxt = rdata_r;
		if (cfg.wr && cfg.addr == `ARB_CTRL_OFF) begin
			ctrl_nxt = cfg.wdata;
		end
		if (cfg.rd) begin
			if (cfg.addr == `ARB_CTRL_OFF) begin
				rdata_nxt = ctrl_r;
			end else if (cfg.addr == `CLK_STAT_OFF) begin
				rdata_nxt = {`STAT_RSVD_ZERO, stop_s};
			end else begin
				rdata_nxt = 8'h00;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl_r <= `ARB_CTRL_RST;
			rdata_r <= 8'h00;
		end else begin
			ctrl_r <= ctrl_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign cfg_rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////////////
	// two-tier arbitration; low tier is slot NUM_MST of the high rotation
	logic [`NUM_MST-1:0] hi_req, lo_req, lo_pick;
	logic [`NUM_MST:0] hi_pick;
	logic [`NUM_MST:0] hi_last_r, hi_last_nxt;
	logic [`NUM_MST-1:0] lo_last_r, lo_last_nxt;
	logic [`NUM_MST-1:0] gnt_r, gnt_nxt, owner_r, owner_nxt;
	arb_pkg::bus_state_t state_r, state_nxt;
	assign hi_req = req_v & ctrl_r.tier_high;
	assign lo_req = req_v & ~ctrl_r.tier_high;
	rr_pick #(.N(`NUM_MST + 1)) u_hi (
		.req({|lo_req, hi_req}),
		.last(hi_last_r),
		.pick(hi_pick)
	);
	rr_pick #(.N(`NUM_MST)) u_lo (
		.req(lo_req),
		.last(lo_last_r),
		.pick(lo_pick)
	);
	always_comb begin
		gnt_nxt = gnt_r;
		owner_nxt = owner_r;
		hi_last_nxt = hi_last_r;
		lo_last_nxt = lo_last_r;
		state_nxt = state_r;
		// grants only move while the bus is idle, so a transfer is never cut off
		if (idle_s) begin
			if (req_v != '0) begin
				hi_last_nxt = hi_pick;
				if (hi_pick[`NUM_MST]) begin
					gnt_nxt = lo_pick;
					lo_last_nxt = lo_pick;
				end else begin
					gnt_nxt = hi_pick[`NUM_MST-1:0];
				end
				owner_nxt = gnt_nxt;
				state_nxt = arb_pkg::ST_OWNED;
			end else begin
				state_nxt = arb_pkg::ST_PARKED;
				if (ctrl_r.park_on_bridge) begin
					gnt_nxt = '0;
					gnt_nxt[`BRIDGE_IDX] = 1'b1;
				end else begin
					gnt_nxt = owner_r;
				end
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!nrst) begin
			gnt_r <= `GNT_RST;
			owner_r <= `GNT_RST;
			hi_last_r <= '0;
			lo_last_r <= '0;
			state_r <= arb_pkg::ST_PARKED;
		end else begin
			gnt_r <= gnt_nxt;
			owner_r <= owner_nxt;
			hi_last_r <= hi_last_nxt;
			lo_last_r <= lo_last_nxt;
			state_r <= state_nxt;
		end
	end
	assign gnt_n = ~gnt_r[`NUM_EXT-1:0];
	assign bridge_gnt = gnt_r[`BRIDGE_IDX];

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	chk_rsvd_zero: assert property (cfg.rd && cfg.addr == `CLK_STAT_OFF |=> cfg_rdata[7:1] == 7'h00)
		else $error("reserved status bits not zero");
	chk_stop_flag: assert property (cfg.rd && cfg.addr == `CLK_STAT_OFF |=> cfg_rdata[0] == $past(stop_s))
		else $error("clock stopped flag wrong");
	chk_ctrl_reset: assert property (@(posedge clk) disable iff (1'b0) !nrst |=> ctrl_r == `ARB_CTRL_RST)
		else $error("control reset value wrong");
	chk_grant_onehot: assert property ($onehot(gnt_r))
		else $error("grant not one-hot");
	chk_grant_req: assert property (idle_s && req_v != '0 |=> (gnt_r & $past(req_v)) != '0)
		else $error("grant to non-requester");
	chk_hi_only: assert property (idle_s && lo_req == '0 && hi_req != '0 |=> (gnt_r & $past(hi_req)) != '0)
		else $error("high tier not granted");
	chk_lo_slot: assert property (idle_s && hi_req == '0 && lo_req != '0 |=> (gnt_r & $past(lo_req)) != '0)
		else $error("low tier slot not granted");
	chk_park_bridge: assert property (idle_s && req_v == '0 && ctrl_r.park_on_bridge |=> bridge_gnt)
		else $error("bus not parked on bridge");
	chk_park_last: assert property (idle_s && req_v == '0 && !ctrl_r.park_on_bridge |=> gnt_r == $past(owner_r))
		else $error("bus not parked on last owner");
	cov_low_win: cover property (idle_s && hi_pick[`NUM_MST] ##1 gnt_r[0]);
	cov_park_bridge: cover property (idle_s && req_v == '0 && ctrl_r.park_on_bridge);
	cov_two_hi: cover property (idle_s && $countones(hi_req) > 1);
	cov_owned_park: cover property (state_r == arb_pkg::ST_OWNED ##1 state_r == arb_pkg::ST_PARKED);
endmodule // sec_arbiter

// File: include/arb_map.svh
/*
 * offsets, field positions and reset values of the secondary arbiter block.
 * assumes it is included by its bare name from the package and the design files.
 */
`ifndef ARB_MAP_SVH
`define ARB_MAP_SVH
`define CLK_STAT_OFF 8'hDA
`define ARB_CTRL_OFF 8'hDC
`define ARB_CTRL_RST 8'h40
`define PARK_BIT 7
`define BRIDGE_TIER_BIT 6
`define NUM_EXT 6
`define NUM_MST 7
`define BRIDGE_IDX 6
`define STAT_RSVD_ZERO 7'h00
`define GNT_RST 7'h40
`endif

// File: include/arb_pkg.sv
/*
 * types shared by the secondary arbiter files.
 * assumes arb_map.svh on the include path.
 */
`include "arb_map.svh"
package arb_pkg;
	typedef struct packed {
		logic park_on_bridge;
		logic [`NUM_MST-1:0] tier_high;
	} arb_ctrl_t;
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} cfg_req_t;
	typedef enum logic {ST_PARKED, ST_OWNED} bus_state_t;
endpackage

// File: verification/pci_masters.sv
/* external masters on the secondary bus.
 assumes the bench says which masters want the bus and when it is idle. */
module pci_masters (
	input wire logic clk,
	input wire logic [5:0] want,
	input wire logic idle_in,
	output logic [5:0] req_n,
	output logic bus_idle
);
	timeunit 1ns;
	timeprecision 1ns;
	// registered: pins move just after an edge, as a real master's would
	always_ff @(posedge clk) begin
		req_n <= ~want;
		bus_idle <= idle_in;
	end
endmodule // pci_masters

// File: verification/tb_sec_arbiter.sv
/* self-checking bench of the secondary arbiter.
 assumes arb_map.svh on the include path and pci_masters as far side. */
`include "arb_map.svh"
module tb_sec_arbiter;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, nrst, bridge_req, stop, idle_in, probe, look_r, sel_r, bridge_gnt, bus_idle;
	logic [5:0] want, req_n, gnt_n;
	logic [7:0] cfg_rdata, e, g;
	arb_pkg::cfg_req_t cfg;
	logic [7:0] q[$];
	int num_errors, n_tests, cyc, seed, r;
	sec_arbiter uut (.clk(clk), .nrst(nrst), .cfg(cfg), .cfg_rdata(cfg_rdata), .req_n(req_n),
		.bridge_req(bridge_req), .bus_idle(bus_idle), .sec_clk_stopped(stop), .gnt_n(gnt_n),
		.bridge_gnt(bridge_gnt));
	pci_masters far (.clk(clk), .want(want), .idle_in(idle_in), .req_n(req_n), .bus_idle(bus_idle));
	////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [7:0] ex, input logic [7:0] got);
		n_tests++;
		if (got !== ex) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, ex, got);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) cfg <= '{a, 1'b1, 1'b0, d};
		@(posedge clk) cfg.wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] ex);
		@(posedge clk) cfg <= '{a, 1'b0, 1'b1, 8'h00};
		q.push_back(ex);
		@(posedge clk) cfg.rd <= 1'b0;
	endtask
	// grant vector {bridge_gnt, gnt_n} noted and looked at two edges on
	task pg(input logic [6:0] ex);
		@(posedge clk) probe <= 1'b1;
		q.push_back({1'b0, ex});
		@(posedge clk) probe <= 1'b0;
	endtask
	// counts grants over n single idle cycles; order-free, so any start point of the rotation passes
	task rot(input logic [7:0] c, input logic [5:0] w, input logic b, input int n, input logic [13:0] ex);
		logic [7:0] cnt[7];
		int i, k;
		wr(`ARB_CTRL_OFF, c);
		want <= w;
		bridge_req <= b;
		for (i = 0; i < 7; i++) cnt[i] = 8'h00;
		repeat (5) @(posedge clk);
		for (k = 0; k < n; k++) begin
			idle_in <= 1'b1;
			@(posedge clk) idle_in <= 1'b0;
			repeat (6) @(posedge clk);
			for (i = 0; i < 6; i++) cnt[i] += !gnt_n[i];
			cnt[6] += bridge_gnt;
		end
		for (i = 0; i < 7; i++) chk("grant_count", {6'h00, ex[2*i+:2]}, cnt[i]);
		$display("rotation test ctrl %h done", c);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			wrap_up;
		end
	end
	always @(posedge clk) begin
		if (look_r) begin
			e = q.pop_front();
			g = sel_r ? {1'b0, bridge_gnt, gnt_n} : cfg_rdata;
			chk(sel_r ? "grants" : "cfg_rdata", e, g);
		end
		look_r <= cfg.rd | probe;
		sel_r <= probe;
	end
	initial begin
		{nrst, bridge_req, stop, idle_in, probe, want} = '0;
		cfg = '0;
		seed = 32'h0620;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		rd(`ARB_CTRL_OFF, `ARB_CTRL_RST);
		rd(`CLK_STAT_OFF, 8'h00);
		wr(`CLK_STAT_OFF, 8'hFF);
		rd(`CLK_STAT_OFF, 8'h00);
		stop <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`CLK_STAT_OFF, 8'h01);
		rd(8'h10, 8'h00);
		$display("register test done");
		repeat (3) begin
			r = $random(seed);
			wr(`ARB_CTRL_OFF, r[7:0]);
			rd(`ARB_CTRL_OFF, r[7:0]);
		end
		rot(8'h05, 6'h07, 1'b0, 3, 14'h0015);
		rot(8'h01, 6'h01, 1'b1, 2, 14'h1001);
		rot(8'h40, 6'h03, 1'b1, 4, 14'h2005);
		bridge_req <= 1'b0;
		want <= 6'h08;
		idle_in <= 1'b1;
		repeat (6) @(posedge clk);
		want <= 6'h00;
		repeat (6) @(posedge clk);
		pg(7'h37);
		wr(`ARB_CTRL_OFF, 8'hC0);
		repeat (4) @(posedge clk);
		pg(7'h7F);
		repeat (3) @(posedge clk);
		$display("parking test done");
		wrap_up;
	end
endmodule // tb_sec_arbiter
